// file: core/isvm_cfg.svh
// Constants for the interrupt source vector map
`ifndef ISVM_CFG_SVH
`define ISVM_CFG_SVH

`define ISVM_NUM_SRC 26
`define ISVM_ORD_W 5
`define ISVM_LVL_W 2
`define ISVM_CNT_W 8
`define ISVM_ADDR_W 16

// Fixed default priority ordinals of the named sources
`define ISVM_ORD_EXT_PIN_ZERO 5'h00
`define ISVM_ORD_THIRD_CAPTURE 5'h01
`define ISVM_ORD_SECOND_CAPTURE 5'h02
`define ISVM_ORD_REFERENCE_CAPTURE 5'h03
`define ISVM_ORD_COMPOSITE_SYNC 5'h05
`define ISVM_ORD_FIRST_CAPTURE 5'h0a
`define ISVM_ORD_CONVERSION_DONE 5'h0e

// Address map: two bytes per ordinal, the last ordinal skips one slot
`define ISVM_VEC_BASE 16'h0006
`define ISVM_CTRL_BASE 16'hfe06
`define ISVM_ADDR_STEP 16'h0002
`define ISVM_ORD_SKIP 5'h19
`define ISVM_VEC_SKIP 16'h003a
`define ISVM_CTRL_SKIP 16'hfe3a

// Reset values
`define ISVM_CNT_RST 8'h00
`define ISVM_ORD_RST 5'h00
`define ISVM_ADDR_RST 16'h0000
`define ISVM_LVL_RST 2'h3

`endif

// file: core/isvm_pkg.sv
// Types for the interrupt source vector map
package isvm_pkg;
  typedef enum logic [1:0] {
    ISVM_MODE_VECTORED,
    ISVM_MODE_CONTEXT,
    ISVM_MODE_COUNT,
    ISVM_MODE_TRANSFER
  } isvm_mode_t;
endpackage

// file: core/isvm_src_cell.sv
// One request source: pending flags and service counter
`timescale 1ns/100ps
`include "isvm_cfg.svh"
module isvm_src_cell #(
  parameter int CNT_W = `ISVM_CNT_W
) (
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic event_in, // One-cycle request event
  input wire isvm_pkg::isvm_mode_t mode, // Handling mode
  input wire logic cnt_load, // Load service counter
  input wire logic [CNT_W-1:0] cnt_value, // Value to load
  input wire logic vec_clear, // Vectored request taken
  input wire logic fast_clear, // Transfer service done
  output logic vec_pend_q, // Vectored request pending
  output logic fast_pend_q, // Transfer service pending
  output logic [CNT_W-1:0] count_q // Service counter
);
  import isvm_pkg::*;

  logic fast_mode;
  logic last_count;

  assign fast_mode = (mode == ISVM_MODE_COUNT) || (mode == ISVM_MODE_TRANSFER);
  assign last_count = (count_q <= CNT_W'(1));

  // Set wins over clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vec_pend_q <= 1'b0;
    end else if (event_in && (!fast_mode || last_count)) begin
      vec_pend_q <= 1'b1; // [RQ11]
    end else if (vec_clear) begin
      vec_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fast_pend_q <= 1'b0;
    end else if (event_in && mode == ISVM_MODE_TRANSFER) begin
      fast_pend_q <= 1'b1; // [RQ2]
    end else if (fast_clear) begin
      fast_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= CNT_W'(`ISVM_CNT_RST);
    end else if (cnt_load) begin
      count_q <= cnt_value;
    end else if (event_in && fast_mode && count_q != CNT_W'(0)) begin
      count_q <= count_q - CNT_W'(1); // [RQ11]
    end
  end
endmodule

// file: core/isvm_top.sv
// Maskable interrupt source table with priority grant and vector lookup
// Notes on behaviour
// RQ1 - Up to 32 sources, each routed to its own vector entry.
// RQ2 - Sources may select context switch or CPU-less transfer service instead.
// RQ3 - External pin zero edge: ordinal 0, vector 0006H, control word FE06H.
// RQ4 - Divider compare into third capture: ordinal 1, vector 0008H, word FE08H.
// RQ5 - Drum speed input edge: ordinal 2, vector 000AH, word FE0AH.
// RQ6 - Playback edge or divider compare into reference capture: ordinal 3, 000CH/FE0CH.
// RQ7 - Composite sync pin edge: ordinal 5, vector 0010H, word FE10H.
// RQ8 - Pin edge or event counter into first capture: ordinal 10, 001AH/FE1AH.
// RQ9 - Conversion done: ordinal 14, vector 0022H, word FE22H.
// RQ10 - Each maskable source gets one of four programmable priority levels.
// RQ11 - Counting mode decrements service counter per request; zero raises vectored interrupt.
// RQ12 - Timer compare sources at ordinals 4,6,7,8,9,11 with their vectors.
// RQ13 - Equal level ties go to the lowest default ordinal.
`timescale 1ns/100ps
`include "isvm_cfg.svh"
module isvm_top #(
  parameter int NUM_SRC = `ISVM_NUM_SRC,
  parameter int CNT_W = `ISVM_CNT_W
) (
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic ext_pin_zero_request, // External pin zero
  input wire logic drum_speed_input, // Drum speed pin
  input wire logic playback_control_signal, // Playback control pin
  input wire logic composite_sync_input, // Composite sync pin
  input wire logic capture_pin, // First capture pin
  input wire logic event_divider_compare, // Divider compare pulse
  input wire logic event_counter, // Event counter pulse
  input wire logic conversion_done, // Conversion end pulse
  input wire logic ref_capture_from_divider, // Reference capture source select
  input wire logic first_capture_from_counter, // First capture source select
  input wire logic [NUM_SRC-1:0] periph_req, // Other on-chip request pulses
  input wire logic [NUM_SRC-1:0] src_mask, // Per-source mask, 1 masks
  input wire logic [2*NUM_SRC-1:0] src_level, // Two-bit level per source
  input wire logic [2*NUM_SRC-1:0] src_mode, // Handling mode per source
  input wire logic [NUM_SRC-1:0] cnt_load, // Per-source counter load
  input wire logic [CNT_W-1:0] cnt_value, // Counter load value
  input wire logic irq_ack, // Presented request taken
  input wire logic fast_ack, // Presented transfer done
  output logic irq_valid_q, // Vectored request presented
  output logic [`ISVM_ORD_W-1:0] irq_ordinal_q, // Its ordinal
  output logic [`ISVM_ADDR_W-1:0] irq_vector_q, // Its vector address
  output logic [`ISVM_LVL_W-1:0] irq_level_q, // Its level
  output logic irq_context_q, // Context switch requested
  output logic fast_valid_q, // Transfer service presented
  output logic [`ISVM_ORD_W-1:0] fast_ordinal_q, // Its ordinal
  output logic [`ISVM_ADDR_W-1:0] fast_ctrl_word_q // Its control word address
);
  import isvm_pkg::*;

  localparam int NPIN = 5;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;
  logic [NPIN-1:0] pin_s3_q;
  logic [NPIN-1:0] pin_rise;
  logic [NUM_SRC-1:0] src_event;
  logic [NUM_SRC-1:0] vec_pend;
  logic [NUM_SRC-1:0] fast_pend;
  logic [NUM_SRC-1:0] vec_clear;
  logic [NUM_SRC-1:0] fast_clear;
  logic best_found;
  logic [`ISVM_ORD_W-1:0] best_ord;
  logic [`ISVM_LVL_W-1:0] best_lvl;
  logic fbest_found;
  logic [`ISVM_ORD_W-1:0] fbest_ord;

  // Ordinal 25 jumps over one unused table slot
  function automatic logic [`ISVM_ADDR_W-1:0] vec_addr(input logic [`ISVM_ORD_W-1:0] ord);
    if (ord == `ISVM_ORD_SKIP) begin
      vec_addr = `ISVM_VEC_SKIP;
    end else begin
      vec_addr = `ISVM_VEC_BASE + `ISVM_ADDR_STEP * {11'h000, ord}; // [RQ1] [RQ12]
    end
  endfunction

  function automatic logic [`ISVM_ADDR_W-1:0] ctrl_addr(input logic [`ISVM_ORD_W-1:0] ord);
    if (ord == `ISVM_ORD_SKIP) begin
      ctrl_addr = `ISVM_CTRL_SKIP;
    end else begin
      ctrl_addr = `ISVM_CTRL_BASE + `ISVM_ADDR_STEP * {11'h000, ord}; // [RQ2]
    end
  endfunction

  function automatic isvm_mode_t mode_of(input int i);
    mode_of = isvm_mode_t'(src_mode[2*i +: 2]);
  endfunction

  // Pin inputs: two-stage sync, third stage for edge detection
  assign pin_raw = {capture_pin, composite_sync_input, playback_control_signal,
                    drum_speed_input, ext_pin_zero_request};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Edge history; resets to the idle low level so no false edge follows reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s3_q <= '0;
    end else begin
      pin_s3_q <= pin_s2_q;
    end
  end

  assign pin_rise = pin_s2_q & ~pin_s3_q;

  // Routing of triggers onto ordinals
  always_comb begin
    src_event = periph_req; // [RQ12]
    src_event[`ISVM_ORD_EXT_PIN_ZERO] = pin_rise[0]; // [RQ3]
    src_event[`ISVM_ORD_THIRD_CAPTURE] = event_divider_compare; // [RQ4]
    src_event[`ISVM_ORD_SECOND_CAPTURE] = pin_rise[1]; // [RQ5]
    src_event[`ISVM_ORD_REFERENCE_CAPTURE] = ref_capture_from_divider ?
        event_divider_compare : pin_rise[2]; // [RQ6]
    src_event[`ISVM_ORD_COMPOSITE_SYNC] = pin_rise[3]; // [RQ7]
    src_event[`ISVM_ORD_FIRST_CAPTURE] = first_capture_from_counter ?
        event_counter : pin_rise[4]; // [RQ8]
    src_event[`ISVM_ORD_CONVERSION_DONE] = conversion_done; // [RQ9]
  end

  // Acknowledge clears only the ordinal shown at that edge
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    assign vec_clear[g] = irq_ack && irq_valid_q && irq_ordinal_q == `ISVM_ORD_W'(g);
    assign fast_clear[g] = fast_ack && fast_valid_q && fast_ordinal_q == `ISVM_ORD_W'(g);
    isvm_src_cell #(
      .CNT_W(CNT_W)
    ) u_cell (
      .clk(clk),
      .arst_n(arst_n),
      .event_in(src_event[g]),
      .mode(isvm_mode_t'(src_mode[2*g +: 2])),
      .cnt_load(cnt_load[g]),
      .cnt_value(cnt_value),
      .vec_clear(vec_clear[g]),
      .fast_clear(fast_clear[g]),
      .vec_pend_q(vec_pend[g]),
      .fast_pend_q(fast_pend[g]),
      .count_q()
    );
  end

  // Vectored grant: lowest level value wins, then lowest ordinal
  // Scanning downwards leaves the lowest ordinal on equal levels
  always_comb begin
    best_found = 1'b0;
    best_ord = `ISVM_ORD_RST;
    best_lvl = `ISVM_LVL_RST;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (vec_pend[i] && !src_mask[i] &&
          (!best_found || src_level[2*i +: 2] <= best_lvl)) begin // [RQ10] [RQ13]
        best_found = 1'b1;
        best_ord = `ISVM_ORD_W'(i);
        best_lvl = src_level[2*i +: 2];
      end
    end
  end

  // Transfer service grant: lowest ordinal first
  always_comb begin
    fbest_found = 1'b0;
    fbest_ord = `ISVM_ORD_RST;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (fast_pend[i] && !src_mask[i]) begin
        fbest_found = 1'b1;
        fbest_ord = `ISVM_ORD_W'(i);
      end
    end
  end

  // Presented vectored request; one idle cycle after each acknowledge
  // Idle cycle hides the grant that still sees the cleared flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_valid_q <= 1'b0;
    end else begin
      irq_valid_q <= best_found && !(irq_ack && irq_valid_q);
    end
  end

  // Payload follows the grant every cycle; meaningful only while valid
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ordinal_q <= `ISVM_ORD_RST;
      irq_vector_q <= `ISVM_ADDR_RST;
      irq_level_q <= `ISVM_LVL_RST;
      irq_context_q <= 1'b0;
    end else begin
      irq_ordinal_q <= best_ord;
      irq_vector_q <= vec_addr(best_ord); // [RQ1]
      irq_level_q <= best_lvl;
      irq_context_q <= mode_of(int'(best_ord)) == ISVM_MODE_CONTEXT; // [RQ2]
    end
  end

  // Transfer service request, same handshake as the vectored one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fast_valid_q <= 1'b0;
    end else begin
      fast_valid_q <= fbest_found && !(fast_ack && fast_valid_q);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fast_ordinal_q <= `ISVM_ORD_RST;
      fast_ctrl_word_q <= `ISVM_ADDR_RST;
    end else begin
      fast_ordinal_q <= fbest_ord;
      fast_ctrl_word_q <= ctrl_addr(fbest_ord); // [RQ2]
    end
  end
endmodule

// file: verif/isvm_top_monitor.sv
// Port-level checker for the interrupt source vector map
`timescale 1ns/100ps
module isvm_top_monitor #(
  parameter int NUM_SRC = 26
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ext_pin_zero_request,
  input wire logic conversion_done,
  input wire logic [NUM_SRC-1:0] src_mask,
  input wire logic [2*NUM_SRC-1:0] src_level,
  input wire logic [2*NUM_SRC-1:0] src_mode,
  input wire logic irq_ack,
  input wire logic fast_ack,
  input wire logic irq_valid_q,
  input wire logic [4:0] irq_ordinal_q,
  input wire logic [15:0] irq_vector_q,
  input wire logic [1:0] irq_level_q,
  input wire logic irq_context_q,
  input wire logic fast_valid_q,
  input wire logic [4:0] fast_ordinal_q,
  input wire logic [15:0] fast_ctrl_word_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Last ordinal skips one table slot
  function automatic logic [15:0] addr(input logic [4:0] o, input logic [15:0] b);
    return (o == 5'h19) ? b + 16'h0034 : b + {10'h000, o, 1'b0};
  endfunction
  property p_vec;
    irq_valid_q |-> irq_vector_q == addr(irq_ordinal_q, 16'h0006);
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_ctl;
    fast_valid_q |-> fast_ctrl_word_q == addr(fast_ordinal_q, 16'hfe06);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control word wrong");
  property p_ack;
    irq_valid_q && irq_ack |=> !irq_valid_q;
  endproperty
  a_ack: assert property (p_ack) else $error("taken request still shown");
  property p_fack;
    fast_valid_q && fast_ack |=> !fast_valid_q;
  endproperty
  a_fack: assert property (p_fack) else $error("done transfer still shown");
  property p_lvl;
    irq_valid_q && $stable(src_level) |-> irq_level_q == src_level[2*irq_ordinal_q +: 2];
  endproperty
  a_lvl: assert property (p_lvl) else $error("level output wrong");
  property p_ctx;
    irq_valid_q && $stable(src_mode) |->
      irq_context_q == (src_mode[2*irq_ordinal_q +: 2] == 2'h1);
  endproperty
  a_ctx: assert property (p_ctx) else $error("context flag wrong");
  sequence s_conv;
    conversion_done && !src_mask[14] && src_mode[29:28] == 2'h0;
  endsequence
  sequence s_conv_grant;
    ##[1:400] (irq_valid_q && irq_ordinal_q == 5'h0e);
  endsequence
  property p_conv;
    s_conv |-> s_conv_grant;
  endproperty
  a_conv: assert property (p_conv) else $error("conversion not granted");
  sequence s_pin0;
    $rose(ext_pin_zero_request) && !src_mask[0] && src_mode[1:0] == 2'h0;
  endsequence
  property p_pin0;
    s_pin0 |-> ##[2:400] (irq_valid_q && irq_ordinal_q == 5'h00);
  endproperty
  a_pin0: assert property (p_pin0) else $error("pin zero not granted");
endmodule
bind isvm_top isvm_top_monitor #(.NUM_SRC(NUM_SRC)) isvm_top_monitor_inst (.*);

// file: verif/isvm_cpu_model.sv
// CPU side model that takes presented requests, fast or slow
`timescale 1ns/100ps
module isvm_cpu_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic irq_valid_q,
  input wire logic fast_valid_q,
  input wire logic slow,
  output logic irq_ack,
  output logic fast_ack
);
  logic [1:0] cnt = 2'h0;
  initial begin
    irq_ack = 1'b0;
    fast_ack = 1'b0;
  end
  // One-cycle acks, never two in a row; slow waits for the counter
  always @(posedge clk) begin
    cnt <= #1 cnt + 2'h1;
    irq_ack <= #1 arst_n && irq_valid_q && !irq_ack && (!slow || cnt == 2'h3);
    fast_ack <= #1 arst_n && fast_valid_q && !fast_ack && (!slow || cnt == 2'h1);
  end
endmodule

// file: verif/test_isvm_top.sv
// Self-checking bench for the interrupt source vector map
`timescale 1ns/100ps
module test_isvm_top;
  logic clk = 0, arst_n = 0, slow = 0, irq_ack, fast_ack;
  logic ext_pin_zero_request = 0, drum_speed_input = 0, playback_control_signal = 0;
  logic composite_sync_input = 0, capture_pin = 0, event_divider_compare = 0;
  logic event_counter = 0, conversion_done = 0, ref_capture_from_divider = 0;
  logic first_capture_from_counter = 0, irq_valid_q, irq_context_q, fast_valid_q;
  logic [25:0] periph_req = '0, src_mask = '0, cnt_load = '0, got, fgot, fired;
  logic [51:0] src_level = '0, src_mode = '0;
  logic [7:0] cnt_value = '0;
  logic [4:0] irq_ordinal_q, fast_ordinal_q;
  logic [4:0] ord_q[$];
  logic [15:0] irq_vector_q, fast_ctrl_word_q;
  logic [1:0] irq_level_q;
  logic [31:0] r = 32'h0000794f;
  int fails = 0, compares = 0;
  isvm_top isvm_top_inst (.*);
  isvm_cpu_model isvm_cpu_model_inst (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [15:0] exp_addr(input logic [4:0] o, input logic [15:0] b);
    return (o == 5'h19) ? b + 16'h0034 : b + {10'h000, o, 1'b0};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("Counts: fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic fire(input int o);
    @(posedge clk);
    #1;
    case (o)
      0: ext_pin_zero_request = 1'b1;
      1: event_divider_compare = 1'b1;
      2: drum_speed_input = 1'b1;
      3: begin
        playback_control_signal = 1'b1;
        event_divider_compare = 1'b1;
      end
      5: composite_sync_input = 1'b1;
      10: begin
        capture_pin = 1'b1;
        event_counter = 1'b1;
      end
      14: conversion_done = 1'b1;
      default: periph_req[o] = 1'b1;
    endcase
    @(posedge clk);
    #1;
    {ext_pin_zero_request, event_divider_compare, drum_speed_input, capture_pin} = '0;
    {playback_control_signal, composite_sync_input, event_counter, conversion_done} = '0;
    periph_req = '0;
  endtask
  task automatic wait_got(input int o);
    int n;
    n = 0;
    while (got[o] !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk("grant", 32'h1, 32'(got[o]));
  endtask
  // Every taken request must carry the table address of its ordinal
  always @(posedge clk) begin
    if (irq_valid_q === 1'b1 && irq_ack === 1'b1) begin
      got[irq_ordinal_q] = 1'b1;
      ord_q.push_back(irq_ordinal_q);
      chk("vector", exp_addr(irq_ordinal_q, 16'h0006), irq_vector_q);
      chk("context", 32'(src_mode[2*irq_ordinal_q +: 2] == 2'h1), 32'(irq_context_q));
    end
    if (fast_valid_q === 1'b1 && fast_ack === 1'b1) begin
      fgot[fast_ordinal_q] = 1'b1;
      chk("ctrl word", exp_addr(fast_ordinal_q, 16'hfe06), fast_ctrl_word_q);
    end
  end
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    fails++;
    end_sim;
  end
  initial begin
    {got, fgot, fired} = '0;
    repeat (11) @(posedge clk);
    chk("reset level", 32'h3, 32'(irq_level_q));
    @(posedge clk);
    #1 arst_n = 1;
    for (int o = 0; o < 26; o++) begin
      got = '0;
      fire(o);
      wait_got(o);
    end
    {ref_capture_from_divider, first_capture_from_counter, got} = {2'h3, 26'h0};
    fire(1);
    wait_got(3);
    fire(10);
    wait_got(10);
    src_level = {26{2'h1}};
    src_level[19:18] = 2'h0;
    ord_q.delete();
    periph_req = 26'h0000250;
    @(posedge clk);
    #1 periph_req = '0;
    repeat (30) @(posedge clk);
    chk("first", 32'h9, 32'(ord_q[0]));
    chk("second", 32'h4, 32'(ord_q[1]));
    chk("third", 32'h6, 32'(ord_q[2]));
    {src_mode[15:12], cnt_load, cnt_value} = {4'he, 26'h40, 8'h03};
    @(posedge clk);
    #1 {cnt_load, cnt_value} = {26'h80, 8'h02};
    @(posedge clk);
    #1 {cnt_load, got, fgot} = '0;
    fire(6);
    fire(6);
    repeat (10) @(posedge clk);
    chk("early count", 32'h0, 32'(got[6]));
    fire(6);
    wait_got(6);
    fire(7);
    repeat (10) @(posedge clk);
    chk("transfer", 32'h1, 32'(fgot[7]));
    chk("transfer vec", 32'h0, 32'(got[7]));
    fire(7);
    wait_got(7);
    {src_mask[20], got} = {1'b1, 26'h0};
    fire(20);
    repeat (10) @(posedge clk);
    chk("masked", 32'h0, 32'(got[20]));
    #1 src_mask = '0;
    wait_got(20);
    r = xs(r);
    {src_mode, src_level, got} = {52'h0, r[19:0], r, 26'h0};
    r = xs(r);
    for (int i = 0; i < 26; i++) begin
      src_mode[2*i] = r[i];
    end
    repeat (300) begin
      @(posedge clk);
      #1 r = xs(r);
      periph_req = (r[8:6] == 3'h0) ? (26'h1 << r[4:0]) & ~26'h000442f : '0;
      {conversion_done, slow} = {r[12:9] == 4'h0, r[15]};
      fired = fired | periph_req;
    end
    @(posedge clk);
    #1 {periph_req, conversion_done} = '0;
    repeat (600) @(posedge clk);
    chk("random grants", 32'(fired), 32'(got & fired));
    end_sim;
  end
endmodule
